/* File: rtl/two_wire_consts.vh */
// constants for the two-wire slave port: register indices, fields, resets, timing
`ifndef TWO_WIRE_CONSTS_VH
`define TWO_WIRE_CONSTS_VH

// register indices (byte address is four times the index)
`define IDX_CTRL_ONE 10'h014
`define IDX_CTRL_TWO 10'h091
`define IDX_STATUS 10'h094
`define IDX_DATA_BUF 10'h013
`define IDX_SLAVE_ADDR 10'h093
`define IDX_IRQ_FLAGS 10'h00C
`define IDX_PIN_DIR 10'h087

// reset values
`define RST_CTRL_ONE 8'h00
`define RST_CTRL_TWO 8'h00
`define RST_STATUS 8'h00
`define RST_SLAVE_ADDR 8'h00
`define RST_PIN_DIR 8'hFF

// control one fields
`define C1_WCOL 7
`define C1_OVF 6
`define C1_EN 5
`define C1_CKP 4
// control two fields
`define C2_GENERAL_CALL_ENABLE 7
`define C2_ACK_STATUS_BIT 6
`define C2_ACK_LEVEL_BIT 5
`define C2_ACK_SEQUENCE_TRIGGER 4
`define C2_MASTER_RECEIVE_ENABLE 3
`define C2_STOP 2
`define C2_RSTART 1
`define C2_START 0
// irq flag position in the peripheral flag register
`define IRQ_BIT 3
// pin direction bits for scl and sda
`define DIR_SCL 3
`define DIR_SDA 4

// mode codes
`define MODE_MASTER 4'h8
`define MODE_FW_MASTER 4'hB
`define MODE_S7 4'h6
`define MODE_S10 4'h7
`define MODE_S7_SS 4'hE
`define MODE_S10_SS 4'hF

// ten-bit address header pattern
`define TEN_HDR 5'h1E

// bus condition hold time and clock rate
`define COND_NS 4700
`define CLK_MHZ 100
`define COND_CYC ((`COND_NS * `CLK_MHZ + 999) / 1000)

// axi responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

/* File: rtl/two_wire_slave_port_ctrl.v */
// two-wire serial port in slave mode with the second control register and axi4-lite access
`timescale 1ns/1ns
`include "two_wire_consts.vh"

module two_wire_slave_port_ctrl (
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // axi4-lite write address and data
  input wire [11:0] awaddr,
  input wire [2:0] awprot,
  input wire awvalid,
  output reg awready,
  input wire [31:0] wdata,
  input wire [3:0] wstrb,
  input wire wvalid,
  output reg wready,
  // axi4-lite write response
  output reg [1:0] bresp,
  output reg bvalid,
  input wire bready,
  // axi4-lite read
  input wire [11:0] araddr,
  input wire [2:0] arprot,
  input wire arvalid,
  output reg arready,
  output reg [31:0] rdata,
  output reg [1:0] rresp,
  output reg rvalid,
  input wire rready,
  // two-wire pins, open drain
  input wire scl_i,
  output reg scl_o,
  output reg scl_oe,
  input wire sda_i,
  output reg sda_o,
  output reg sda_oe
);

  localparam ST_IDLE = 2'h0;
  localparam ST_ADDR = 2'h1;
  localparam ST_RX = 2'h2;
  localparam ST_TX = 2'h3;
  localparam integer COND_CYC_I = `COND_CYC;
  localparam [9:0] COND_LAST = COND_CYC_I[9:0] - 10'h001;
  localparam [9:0] COND_HALF = COND_CYC_I[10:1];

  reg scl_m_q, scl_s_q, scl_p_q, sda_m_q, sda_s_q, sda_p_q;
  reg [7:0] ctrl_one_q, ctrl_two_q, data_buf_q, slave_addr_q, pin_dir_q, shift_q, hi_byte_q;
  reg [1:0] smp_cke_q, state_q, next_q;
  reg data_addr_q, stop_seen_q, start_seen_q, rw_q, ua_q, bf_q, irq_q;
  reg [3:0] bitcnt_q;
  reg ack_pull_q, done_q, ua_hold_q, ten_hi_q, ten_done_q;
  reg [9:0] mtmr_q;
  reg [7:0] rd_mux;
  reg rd_ok, acc, set_ua, is_read, is_data;
  reg [1:0] nxt;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers and bus condition detection
  always @(posedge aclk) begin
    if (!aresetn) begin
      scl_m_q <= 1'b1;
      scl_s_q <= 1'b1;
      scl_p_q <= 1'b1;
      sda_m_q <= 1'b1;
      sda_s_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_m_q <= scl_i;
      scl_s_q <= scl_m_q;
      scl_p_q <= scl_s_q;
      sda_m_q <= sda_i;
      sda_s_q <= sda_m_q;
      sda_p_q <= sda_s_q;
    end
  end

  wire scl_rise = scl_s_q & ~scl_p_q;
  wire scl_fall = ~scl_s_q & scl_p_q;
  wire start_det = ~sda_s_q & sda_p_q & scl_s_q & scl_p_q;
  wire stop_det = sda_s_q & ~sda_p_q & scl_s_q & scl_p_q;

  // mode decode
  wire [3:0] mode = ctrl_one_q[3:0];
  wire enabled = ctrl_one_q[`C1_EN];
  wire is_master = (mode == `MODE_MASTER) | (mode == `MODE_FW_MASTER);
  wire is_slave = (mode == `MODE_S7) | (mode == `MODE_S10) | (mode == `MODE_S7_SS) |
    (mode == `MODE_S10_SS);
  wire ten_bit = is_slave & mode[0];
  wire ss_irq = is_slave & mode[3];
  wire pins_ok = enabled & (is_master | is_slave) & pin_dir_q[`DIR_SCL] & pin_dir_q[`DIR_SDA];
  wire m_busy = is_master & (|ctrl_two_q[4:0]);
  wire m_cond = ctrl_two_q[`C2_ACK_SEQUENCE_TRIGGER] | ctrl_two_q[`C2_STOP] | ctrl_two_q[`C2_RSTART] |
    (is_master & ctrl_two_q[`C2_START]);

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite handshakes: address and data taken together, one at a time
  wire wr_go = awvalid & wvalid & ~awready & ~bvalid;
  wire rd_go = arvalid & ~arready & ~rvalid;
  wire [9:0] wr_idx = awaddr[11:2];
  wire [9:0] rd_idx = araddr[11:2];
  wire wr_hit = (wr_idx == `IDX_CTRL_ONE) | (wr_idx == `IDX_CTRL_TWO) |
    (wr_idx == `IDX_STATUS) | (wr_idx == `IDX_DATA_BUF) | (wr_idx == `IDX_SLAVE_ADDR) |
    (wr_idx == `IDX_IRQ_FLAGS) | (wr_idx == `IDX_PIN_DIR);
  wire wr_en = wr_go & wr_hit & wstrb[0];

  always @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= `RESP_OKAY;
      arready <= 1'b0;
      rvalid <= 1'b0;
      rresp <= `RESP_OKAY;
      rdata <= 32'h0;
    end else begin
      awready <= wr_go;
      wready <= wr_go;
      if (wr_go) begin
        bvalid <= 1'b1;
        bresp <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
      end else if (bready) begin
        bvalid <= 1'b0;
      end
      arready <= rd_go;
      if (rd_go) begin
        rvalid <= 1'b1;
        rresp <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
        rdata <= {24'h0, rd_mux};
      end else if (rready) begin
        rvalid <= 1'b0;
      end
    end
  end

  // read data select
  always @* begin
    rd_ok = 1'b1;
    case (rd_idx)
      `IDX_CTRL_ONE: rd_mux = ctrl_one_q;
      `IDX_CTRL_TWO: rd_mux = ctrl_two_q;
      `IDX_STATUS: rd_mux = {smp_cke_q, data_addr_q, stop_seen_q, start_seen_q, rw_q, ua_q, bf_q};
      `IDX_DATA_BUF: rd_mux = data_buf_q;
      `IDX_SLAVE_ADDR: rd_mux = slave_addr_q;
      `IDX_IRQ_FLAGS: rd_mux = {4'h0, irq_q, 3'h0};
      `IDX_PIN_DIR: rd_mux = pin_dir_q;
      default: begin
        rd_mux = 8'h00;
        rd_ok = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // address match decision for the byte just shifted in
  always @* begin
    acc = 1'b0;
    set_ua = 1'b0;
    is_read = rw_q;
    is_data = 1'b0;
    nxt = ST_IDLE;
    if (state_q == ST_RX) begin
      acc = 1'b1;
      is_data = 1'b1;
      nxt = ST_RX;
    end else if (state_q == ST_ADDR) begin
      if (ctrl_two_q[`C2_GENERAL_CALL_ENABLE] && shift_q == 8'h00) begin
        acc = 1'b1;
        is_read = 1'b0;
        nxt = ST_RX;
      end else if (!ten_bit) begin
        if (shift_q[7:1] == slave_addr_q[7:1]) begin
          acc = 1'b1;
          is_read = shift_q[0];
          nxt = shift_q[0] ? ST_TX : ST_RX;
        end
      end else if (ten_done_q) begin
        if (shift_q[7:1] == hi_byte_q[7:1] && shift_q[0]) begin
          acc = 1'b1;
          is_read = 1'b1;
          nxt = ST_TX;
        end
      end else if (ten_hi_q) begin
        if (shift_q == slave_addr_q) begin
          acc = 1'b1;
          set_ua = 1'b1;
          is_read = 1'b0;
          nxt = ST_RX;
        end
      end else if (shift_q[7:3] == `TEN_HDR && !shift_q[0] &&
                   shift_q[7:1] == slave_addr_q[7:1]) begin
        acc = 1'b1;
        set_ua = 1'b1;
        is_read = 1'b0;
        nxt = ST_ADDR;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers, software access and the slave sequencer
  always @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_one_q <= `RST_CTRL_ONE;
      ctrl_two_q <= `RST_CTRL_TWO;
      {smp_cke_q, data_addr_q, stop_seen_q, start_seen_q, rw_q, ua_q, bf_q} <= `RST_STATUS;
      data_buf_q <= 8'h00;
      slave_addr_q <= `RST_SLAVE_ADDR;
      pin_dir_q <= `RST_PIN_DIR;
      irq_q <= 1'b0;
      shift_q <= 8'h00;
      hi_byte_q <= 8'h00;
      state_q <= ST_IDLE;
      next_q <= ST_IDLE;
      bitcnt_q <= 4'h0;
      ack_pull_q <= 1'b0;
      done_q <= 1'b0;
      ua_hold_q <= 1'b0;
      ten_hi_q <= 1'b0;
      ten_done_q <= 1'b0;
      mtmr_q <= 10'h000;
    end else begin
      // software writes first, so hardware sets below win in the same cycle
      if (wr_en) begin
        case (wr_idx)
          `IDX_CTRL_ONE: ctrl_one_q <= wdata[7:0];
          `IDX_CTRL_TWO: begin
            ctrl_two_q[`C2_GENERAL_CALL_ENABLE] <= wdata[`C2_GENERAL_CALL_ENABLE];
            ctrl_two_q[`C2_ACK_LEVEL_BIT] <= wdata[`C2_ACK_LEVEL_BIT];
            if (!m_busy)
              ctrl_two_q[4:0] <= wdata[4:0];
          end
          `IDX_STATUS: smp_cke_q <= wdata[7:6];
          `IDX_DATA_BUF: begin
            if (m_busy) begin
              ctrl_one_q[`C1_WCOL] <= 1'b1;
            end else begin
              data_buf_q <= wdata[7:0];
              shift_q <= wdata[7:0];
              if (is_slave && rw_q)
                bf_q <= 1'b1;
            end
          end
          `IDX_SLAVE_ADDR: begin
            slave_addr_q <= wdata[7:0];
            ua_q <= 1'b0;
            ua_hold_q <= 1'b0;
          end
          `IDX_IRQ_FLAGS: irq_q <= wdata[`IRQ_BIT];
          `IDX_PIN_DIR: pin_dir_q <= wdata[7:0];
          default: ;
        endcase
      end
      // reading the buffer empties it
      if (rd_go && rd_idx == `IDX_DATA_BUF)
        bf_q <= 1'b0;

      // master conditions run a fixed hold then self-clear
      if (m_cond && is_master) begin
        if (mtmr_q == COND_LAST) begin
          mtmr_q <= 10'h000;
          ctrl_two_q[`C2_ACK_SEQUENCE_TRIGGER] <= 1'b0;
          ctrl_two_q[`C2_STOP] <= 1'b0;
          ctrl_two_q[`C2_RSTART] <= 1'b0;
          ctrl_two_q[`C2_START] <= 1'b0;
        end else begin
          mtmr_q <= mtmr_q + 10'h001;
        end
      end else begin
        mtmr_q <= 10'h000;
      end

      if (!enabled) begin
        // disabled port drops the sequencer state and the start and stop flags, keeping the other status bits
        state_q <= ST_IDLE;
        bitcnt_q <= 4'h0;
        ack_pull_q <= 1'b0;
        done_q <= 1'b0;
        ua_hold_q <= 1'b0;
        ten_hi_q <= 1'b0;
        ten_done_q <= 1'b0;
        start_seen_q <= 1'b0;
        stop_seen_q <= 1'b0;
      end else if (start_det) begin
        state_q <= is_slave ? ST_ADDR : ST_IDLE;
        bitcnt_q <= 4'h0;
        ack_pull_q <= 1'b0;
        done_q <= 1'b0;
        start_seen_q <= 1'b1;
        stop_seen_q <= 1'b0;
        if (ss_irq)
          irq_q <= 1'b1;
      end else if (stop_det) begin
        state_q <= ST_IDLE;
        bitcnt_q <= 4'h0;
        ack_pull_q <= 1'b0;
        done_q <= 1'b0;
        ten_hi_q <= 1'b0;
        ten_done_q <= 1'b0;
        start_seen_q <= 1'b0;
        stop_seen_q <= 1'b1;
        if (ss_irq)
          irq_q <= 1'b1;
      end else if (scl_rise) begin
        bitcnt_q <= bitcnt_q + 4'h1;
        if (bitcnt_q < 4'h8 && (state_q == ST_ADDR || state_q == ST_RX ||
            (is_master && ctrl_two_q[`C2_MASTER_RECEIVE_ENABLE])))
          shift_q <= {shift_q[6:0], sda_s_q};
        if (bitcnt_q == 4'h7 && is_master && ctrl_two_q[`C2_MASTER_RECEIVE_ENABLE]) begin
          data_buf_q <= {shift_q[6:0], sda_s_q};
          bf_q <= 1'b1;
          irq_q <= 1'b1;
          ctrl_two_q[`C2_MASTER_RECEIVE_ENABLE] <= 1'b0;
        end
        if (bitcnt_q == 4'h8 && is_master && !ctrl_two_q[`C2_MASTER_RECEIVE_ENABLE])
          ctrl_two_q[`C2_ACK_STATUS_BIT] <= sda_s_q;
        if (bitcnt_q == 4'h8 && state_q == ST_TX && sda_s_q) begin
          state_q <= ST_IDLE;
          done_q <= 1'b0;
          {data_addr_q, rw_q, ua_q} <= 3'h0;
        end
      end else if (scl_fall) begin
        if (state_q == ST_TX && bitcnt_q > 4'h0 && bitcnt_q < 4'h8)
          shift_q <= {shift_q[6:0], 1'b0};
        if (bitcnt_q == 4'h8) begin
          if (state_q == ST_TX) begin
            bf_q <= 1'b0;
            done_q <= 1'b1;
            next_q <= ST_TX;
          end else if (acc) begin
            done_q <= 1'b1;
            next_q <= nxt;
            rw_q <= is_read;
            data_addr_q <= is_data;
            if (set_ua)
              ua_q <= 1'b1;
            if (set_ua && !ten_hi_q) begin
              ten_hi_q <= 1'b1;
              hi_byte_q <= shift_q;
            end
            if (set_ua && ten_hi_q)
              ten_done_q <= 1'b1;
            if (bf_q || ctrl_one_q[`C1_OVF]) begin
              ctrl_one_q[`C1_OVF] <= 1'b1;
            end else begin
              data_buf_q <= shift_q;
              bf_q <= 1'b1;
              ack_pull_q <= 1'b1;
            end
          end else if (state_q == ST_ADDR) begin
            state_q <= ST_IDLE;
          end
        end
        if (bitcnt_q == 4'h9) begin
          bitcnt_q <= 4'h0;
          ack_pull_q <= 1'b0;
          done_q <= 1'b0;
          if (done_q) begin
            irq_q <= 1'b1;
            state_q <= next_q;
            if (ua_q)
              ua_hold_q <= 1'b1;
            if (state_q == ST_ADDR && next_q == ST_TX)
              ctrl_one_q[`C1_CKP] <= 1'b0;
            if (state_q == ST_TX && !bf_q)
              ctrl_one_q[`C1_CKP] <= 1'b0;
            if (state_q == ST_RX && ctrl_two_q[`C2_START] && bf_q)
              ctrl_one_q[`C1_CKP] <= 1'b0;
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // open-drain pin drivers, registered
  // the last data bit stands through the eighth high time, until the eighth fall
  wire tx_low = (state_q == ST_TX) & ((bitcnt_q < 4'h8) | ((bitcnt_q == 4'h8) & ~done_q)) &
    ~shift_q[7];
  wire m_sda_low = ctrl_two_q[`C2_START] | ctrl_two_q[`C2_RSTART] |
    (ctrl_two_q[`C2_STOP] & (mtmr_q < COND_HALF)) |
    (ctrl_two_q[`C2_ACK_SEQUENCE_TRIGGER] & ~ctrl_two_q[`C2_ACK_LEVEL_BIT]);
  wire scl_low_d = pins_ok & is_slave & (~ctrl_one_q[`C1_CKP] | ua_hold_q);
  wire sda_low_d = pins_ok & ((is_slave & (ack_pull_q | tx_low)) | (is_master & m_sda_low));

  always @(posedge aclk) begin
    if (!aresetn) begin
      scl_o <= 1'b0;
      sda_o <= 1'b0;
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
    end else begin
      scl_o <= 1'b0;
      sda_o <= 1'b0;
      scl_oe <= scl_low_d;
      sda_oe <= sda_low_d;
    end
  end

endmodule // two_wire_slave_port_ctrl

/* File: testbench/two_wire_slave_port_ctrl_properties.sv */
// assertion checker for the two-wire slave port
`timescale 1ns/1ns
module two_wire_port_checker (
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // register bus
  input wire awvalid,
  input wire wvalid,
  input wire awready,
  input wire wready,
  input wire bvalid,
  input wire arvalid,
  input wire arready,
  input wire rvalid,
  input wire [31:0] rdata,
  // two-wire pins
  input wire scl_i,
  input wire scl_o,
  input wire sda_o,
  input wire scl_oe,
  input wire sda_oe
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////
  // pins only ever pull low
  property p_od; !(scl_o || sda_o); endproperty
  a_od: assert property (p_od) else $error("pin output not low");
  // stretching only starts once scl is already low
  property p_scl_hold; $rose(scl_oe) |-> !scl_i; endproperty
  a_scl_hold: assert property (p_scl_hold) else $error("scl pulled while high");
  // data and acknowledge change only while scl is low
  property p_sda_chg; $changed(sda_oe) |-> !scl_i; endproperty
  a_sda_chg: assert property (p_sda_chg) else $error("sda moved with scl high");
  // a write is taken and answered one cycle later
  property p_wr; awvalid && wvalid && !awready && !bvalid |=> awready && wready && bvalid;
  endproperty
  a_wr: assert property (p_wr) else $error("write not answered");
  property p_one; awready |=> !awready; endproperty
  a_one: assert property (p_one) else $error("awready longer than one cycle");
  property p_bcause; $rose(bvalid) |-> $past(awvalid && wvalid); endproperty
  a_bcause: assert property (p_bcause) else $error("response without request");
  // a read is answered one cycle later with a byte
  property p_rd; arvalid && !arready && !rvalid |=> arready && rvalid; endproperty
  a_rd: assert property (p_rd) else $error("read not answered");
  property p_rhi; rvalid |-> rdata[31:8] == 24'h0; endproperty
  a_rhi: assert property (p_rhi) else $error("read data upper bits set");
  ////////////////////////////////////////
  // main scenarios
  c_ack: cover property ($rose(sda_oe));
  c_str: cover property ($rose(scl_oe));
  c_rel: cover property ($fell(scl_oe));
endmodule // two_wire_port_checker
bind two_wire_slave_port_ctrl two_wire_port_checker u_two_wire_port_checker (
  .aclk, .aresetn, .awvalid, .wvalid, .awready, .wready, .bvalid, .arvalid, .arready,
  .rvalid, .rdata, .scl_i, .scl_o, .sda_o, .scl_oe, .sda_oe);

/* File: testbench/two_wire_master_model.sv */
// behavioural two-wire bus master on the far side of the slave port
`timescale 1ns/1ns
module two_wire_master_model (
  // clock
  input wire aclk,
  // wired line levels
  input wire scl,
  input wire sda,
  // pull-downs, high pulls the line low
  output logic scl_low,
  output logic sda_low
);
  // lines released at time zero, pull-ups give idle high
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end
  ////////////////////////////////////////
  // half bit time, long enough for the pin synchronisers
  task automatic hold();
    repeat (8) @(posedge aclk);
  endtask
  // release scl and wait while a slave stretches it
  task automatic clk_hi();
    int n = 0;
    scl_low <= 1'b0;
    @(posedge aclk);
    while (!scl && n < 4000) begin
      @(posedge aclk);
      n++;
    end
    hold();
  endtask
  // start or repeated start: sda falls while scl high
  task automatic start();
    sda_low <= 1'b0;
    clk_hi();
    sda_low <= 1'b1;
    hold();
    scl_low <= 1'b1;
    hold();
  endtask
  // stop: sda rises while scl high
  task automatic stop();
    sda_low <= 1'b1;
    hold();
    clk_hi();
    sda_low <= 1'b0;
    hold();
  endtask
  // nine bits msb first, the ninth is the acknowledge slot
  task automatic bits9(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--) begin
      sda_low <= !tx[i];
      hold();
      clk_hi();
      rx[i] = sda;
      scl_low <= 1'b1;
      hold();
    end
  endtask
endmodule // two_wire_master_model

/* File: testbench/two_wire_slave_port_ctrl_tb_top.sv */
// self-checking bench for the two-wire slave port
`timescale 1ns/1ns
`include "two_wire_consts.vh"
module two_wire_slave_port_ctrl_tb_top;
  localparam logic [11:0] adr_c1 = {`IDX_CTRL_ONE, 2'b00};
  localparam logic [11:0] adr_c2 = {`IDX_CTRL_TWO, 2'b00};
  localparam logic [11:0] adr_st = {`IDX_STATUS, 2'b00};
  localparam logic [11:0] adr_buf = {`IDX_DATA_BUF, 2'b00};
  localparam logic [11:0] adr_sa = {`IDX_SLAVE_ADDR, 2'b00};
  localparam logic [11:0] adr_irq = {`IDX_IRQ_FLAGS, 2'b00};
  localparam logic [11:0] adr_dir = {`IDX_PIN_DIR, 2'b00};
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic [31:0] wdata = 32'h0, d;
  logic [3:0] wstrb = 4'hF;
  logic [2:0] awprot = 3'h0, arprot = 3'h0;
  logic [1:0] r;
  logic [8:0] rx;
  wire [31:0] rdata;
  wire [1:0] bresp, rresp;
  wire awready, wready, bvalid, arready, rvalid, scl_o, sda_o, scl_oe, sda_oe, m_scl, m_sda;
  int n_mismatch = 0;
  int samples_checked = 0;
  // wired-and lines with pull-ups
  wire scl = !(m_scl || scl_oe);
  wire sda = !(m_sda || sda_oe);
  two_wire_slave_port_ctrl u_two_wire_slave_port_ctrl (.aclk, .aresetn, .awaddr, .awprot,
    .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
    .arprot, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .scl_i(scl), .scl_o,
    .scl_oe, .sda_i(sda), .sda_o, .sda_oe);
  two_wire_master_model u_two_wire_master_model (.aclk, .scl, .sda, .scl_low(m_scl),
    .sda_low(m_sda));
  // free-running 100 MHz clock
  initial begin
    forever #5 aclk = ~aclk;
  end
  ////////////////////////////////////////
  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // register write, address and data offered together
  task automatic wr(input logic [11:0] a, input logic [7:0] v);
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h0, v};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!(awready && wready));
    while (!bvalid) @(posedge aclk);
    r = bresp;
    bready <= 1'b0;
  endtask
  // register read into d and r
  task automatic rd(input logic [11:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  task automatic rc(input logic [11:0] a, input logic [7:0] m, input logic [7:0] e);
    rd(a);
    chk(d & m, e);
  endtask
  // one byte from the master, acknowledge level compared
  task automatic xb(input logic [7:0] b, input logic ak);
    u_two_wire_master_model.bits9({b, 1'b1}, rx);
    chk(rx[0], ak);
  endtask
  ////////////////////////////////////////
  // watchdog
  initial begin
    repeat (30000) @(posedge aclk);
    n_mismatch++;
    end_sim();
  end
  // test sequence
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    rc(adr_c2, 8'hFF, 8'h00);
    rc(adr_dir, 8'hFF, 8'hFF);
    rd(12'h000);
    chk(r, 2'h2);
    wr(12'h000, 8'h00);
    chk(r, 2'h2);
    wr(adr_c2, 8'h81);
    rc(adr_c2, 8'hFF, 8'h81);
    wr(adr_sa, 8'h84);
    wr(adr_c1, 8'h36);
    u_two_wire_master_model.start();
    xb(8'h84, 1'b0);
    rc(adr_st, 8'h05, 8'h01);
    rc(adr_irq, 8'h08, 8'h08);
    wr(adr_irq, 8'h00);
    rc(adr_buf, 8'hFF, 8'h84);
    rc(adr_st, 8'h01, 8'h00);
    wr(adr_c1, 8'h36);
    xb(8'h5A, 1'b0);
    chk(scl_oe, 32'h1);
    wr(adr_c1, 8'h36);
    xb(8'hC3, 1'b1);
    rc(adr_c1, 8'h40, 8'h40);
    rc(adr_buf, 8'hFF, 8'h5A);
    wr(adr_c1, 8'h36);
    rc(adr_c1, 8'h40, 8'h00);
    // read transfer under a repeated start
    u_two_wire_master_model.start();
    xb(8'h85, 1'b0);
    rc(adr_st, 8'h04, 8'h04);
    chk(scl_oe, 32'h1);
    rd(adr_buf);
    wr(adr_buf, 8'hA5);
    wr(adr_c1, 8'h36);
    u_two_wire_master_model.bits9(9'h1FF, rx);
    chk(rx[8:1], 8'hA5);
    rc(adr_st, 8'h07, 8'h00);
    u_two_wire_master_model.stop();
    // general call
    u_two_wire_master_model.start();
    xb(8'h00, 1'b0);
    rc(adr_buf, 8'hFF, 8'h00);
    wr(adr_c1, 8'h36);
    u_two_wire_master_model.stop();
    // ten-bit address, high byte then low byte
    wr(adr_sa, 8'hF2);
    wr(adr_c1, 8'h37);
    u_two_wire_master_model.start();
    xb(8'hF2, 1'b0);
    rc(adr_st, 8'h02, 8'h02);
    chk(scl_oe, 32'h1);
    rc(adr_buf, 8'hFF, 8'hF2);
    wr(adr_sa, 8'h34);
    xb(8'h34, 1'b0);
    wr(adr_sa, 8'hF2);
    rd(adr_buf);
    u_two_wire_master_model.stop();
    // port disabled: no acknowledge
    wr(adr_c1, 8'h06);
    u_two_wire_master_model.start();
    xb(8'h84, 1'b1);
    u_two_wire_master_model.stop();
    // master triggers, far side holds scl low so the bus stays quiet
    u_two_wire_master_model.scl_low <= 1'b1;
    wr(adr_c1, 8'h28);
    wr(adr_c2, 8'h01);
    rc(adr_c2, 8'h01, 8'h01);
    chk(sda_oe, 32'h1);
    wr(adr_buf, 8'h11);
    rc(adr_c1, 8'h80, 8'h80);
    repeat (480) @(posedge aclk);
    rc(adr_c2, 8'h01, 8'h00);
    wr(adr_c2, 8'h10);
    rc(adr_c2, 8'h10, 8'h10);
    chk(sda_oe, 32'h1);
    repeat (480) @(posedge aclk);
    rc(adr_c2, 8'h10, 8'h00);
    chk(sda_oe, 32'h0);
    end_sim();
  end
endmodule // two_wire_slave_port_ctrl_tb_top
